// *** include/cpr_pkg.sv ***
// shared constants, enums and carriers of the programmer register set
package cpr_pkg;

  // ***********************************************************
  // reset values and fixed addresses
  // ***********************************************************
  localparam logic [15:0] CPR_VEC_HI_ADDR = 16'hfffe;
  localparam logic [15:0] CPR_VEC_LO_ADDR = 16'hffff;
  localparam logic [15:0] CPR_SP_RESET    = 16'h00ff;
  localparam logic [7:0]  CPR_H_RESET     = 8'h00;
  localparam logic [15:0] CPR_PC_RESET    = 16'h0000;
  localparam logic [7:0]  CPR_CCR_RESET   = 8'h68;
  localparam logic [7:0]  CPR_CCR_FIXED   = 8'h60;
  localparam logic [7:0]  CPR_DIRECT_HI   = 8'h00;
  localparam logic [15:0] CPR_PC_STEP     = 16'h0001;
  localparam logic [15:0] CPR_SP_STEP     = 16'h0001;

  // ***********************************************************
  // condition flag bit positions
  // ***********************************************************
  localparam int CPR_CCR_V = 7;
  localparam int CPR_CCR_H = 4;
  localparam int CPR_CCR_I = 3;
  localparam int CPR_CCR_N = 2;
  localparam int CPR_CCR_Z = 1;
  localparam int CPR_CCR_C = 0;

  // ***********************************************************
  // enumerations
  // ***********************************************************
  typedef enum logic [4:0] {
    CPR_OP_NOP    = 5'b00000,
    CPR_OP_FETCH  = 5'b00001,
    CPR_OP_LOAD   = 5'b00010,
    CPR_OP_STORE  = 5'b00011,
    CPR_OP_ALU_A  = 5'b00100,
    CPR_OP_ALU_X  = 5'b00101,
    CPR_OP_TAX    = 5'b00110,
    CPR_OP_TXA    = 5'b00111,
    CPR_OP_LDHX   = 5'b01000,
    CPR_OP_AIS    = 5'b01001,
    CPR_OP_RSP    = 5'b01010,
    CPR_OP_LDSP   = 5'b01011,
    CPR_OP_JUMP   = 5'b01100,
    CPR_OP_BRANCH = 5'b01101,
    CPR_OP_PUSH   = 5'b01110,
    CPR_OP_PULL   = 5'b01111,
    CPR_OP_SETCCR = 5'b10000,
    CPR_OP_LDH    = 5'b10001,
    CPR_OP_LDX    = 5'b10010
  } cpr_op_type;

  typedef enum logic [2:0] {
    CPR_AM_IMM = 3'b000,
    CPR_AM_DIR = 3'b001,
    CPR_AM_EXT = 3'b010,
    CPR_AM_IDX = 3'b011,
    CPR_AM_SPX = 3'b100
  } cpr_mode_type;

  typedef enum logic [3:0] {
    CPR_ALU_ADD = 4'h0, CPR_ALU_ADC = 4'h1, CPR_ALU_SUB = 4'h2, CPR_ALU_AND = 4'h3,
    CPR_ALU_ORA = 4'h4, CPR_ALU_EOR = 4'h5, CPR_ALU_CLR = 4'h6, CPR_ALU_INC = 4'h7,
    CPR_ALU_DEC = 4'h8, CPR_ALU_COM = 4'h9, CPR_ALU_NEG = 4'ha, CPR_ALU_LSL = 4'hb,
    CPR_ALU_LSR = 4'hc, CPR_ALU_ASR = 4'hd, CPR_ALU_ROL = 4'he, CPR_ALU_ROR = 4'hf
  } cpr_alu_type;

  typedef enum logic [2:0] {
    CPR_SEL_A   = 3'b000,
    CPR_SEL_X   = 3'b001,
    CPR_SEL_H   = 3'b010,
    CPR_SEL_CCR = 3'b011,
    CPR_SEL_PCL = 3'b100,
    CPR_SEL_PCH = 3'b101
  } cpr_sel_type;

  typedef enum logic [1:0] {
    CPR_ST_VEC_HI = 2'b00,
    CPR_ST_VEC_LO = 2'b01,
    CPR_ST_RUN    = 2'b10,
    CPR_ST_MEM    = 2'b11
  } cpr_state_type;

  typedef enum logic [2:0] {
    CPR_MK_LOADA = 3'b000,
    CPR_MK_FETCH = 3'b001,
    CPR_MK_PUSH  = 3'b010,
    CPR_MK_PULL  = 3'b011,
    CPR_MK_STORE = 3'b100
  } cpr_kind_type;

  // ***********************************************************
  // carriers
  // ***********************************************************
  typedef struct packed {
    cpr_op_type   op;
    cpr_mode_type mode;
    cpr_alu_type  alu;
    cpr_sel_type  sel;
    logic [7:0]   imm8;
    logic [15:0]  imm16;
  } cpr_cmd_type;

  typedef struct packed {
    logic [7:0]  acc;
    logic [15:0] hx;
    logic [15:0] sp;
    logic [15:0] pc;
    logic [7:0]  condition_flags;
  } cpr_view_type;

  typedef struct packed {
    logic v;
    logic h;
    logic n;
    logic z;
    logic c;
  } cpr_flag_type;

  function automatic logic [15:0] cpr_sext8(input logic [7:0] b);
    return {{8{b[7]}}, b};
  endfunction

endpackage

// *** hdl/cpr_alu8.sv ***
// eight-bit arithmetic and shift unit shared by the accumulator and low index byte
`timescale 1ns/1ps
`default_nettype none
module cpr_alu8
  import cpr_pkg::*;
(
  // operation and operands
  input  wire cpr_alu_type  op,
  input  wire logic [7:0]   a,
  input  wire logic [7:0]   b,
  input  wire logic         cin,
  // result
  output logic [7:0]        res,
  output cpr_flag_type      flags
);

  logic [8:0] sum9;
  logic [4:0] nib5;
  logic       carry;
  logic       ovf;

  always_comb begin
    sum9  = 9'h000;
    nib5  = 5'h00;
    res   = a;
    carry = cin;
    ovf   = 1'b0;
    unique case (op)
      CPR_ALU_ADD, CPR_ALU_ADC: begin
        sum9  = {1'b0, a} + {1'b0, b} + {8'h00, (op == CPR_ALU_ADC) & cin};
        nib5  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, (op == CPR_ALU_ADC) & cin};
        res   = sum9[7:0];
        carry = sum9[8];
        ovf   = (a[7] == b[7]) && (sum9[7] != a[7]);
      end
      CPR_ALU_SUB: begin
        sum9  = {1'b0, a} - {1'b0, b};
        res   = sum9[7:0];
        carry = sum9[8];
        ovf   = (a[7] != b[7]) && (sum9[7] != a[7]);
      end
      CPR_ALU_AND: res = a & b;
      CPR_ALU_ORA: res = a | b;
      CPR_ALU_EOR: res = a ^ b;
      CPR_ALU_CLR: res = 8'h00;
      CPR_ALU_INC: begin
        res = a + 8'h01;
        ovf = (a == 8'h7f);
      end
      CPR_ALU_DEC: begin
        res = a - 8'h01;
        ovf = (a == 8'h80);
      end
      CPR_ALU_COM: begin
        res   = ~a;
        carry = 1'b1;
      end
      CPR_ALU_NEG: begin
        res   = 8'h00 - a;
        carry = (a != 8'h00);
        ovf   = (a == 8'h80);
      end
      CPR_ALU_LSL: begin
        res   = {a[6:0], 1'b0};
        carry = a[7];
        ovf   = a[6] ^ a[7];
      end
      CPR_ALU_LSR: begin
        res   = {1'b0, a[7:1]};
        carry = a[0];
        ovf   = a[0];
      end
      CPR_ALU_ASR: begin
        res   = {a[7], a[7:1]};
        carry = a[0];
        ovf   = a[7] ^ a[0];
      end
      CPR_ALU_ROL: begin
        res   = {a[6:0], cin};
        carry = a[7];
        ovf   = a[6] ^ a[7];
      end
      CPR_ALU_ROR: begin
        res   = {cin, a[7:1]};
        carry = a[0];
        ovf   = cin ^ a[0];
      end
    endcase
    flags.v = ovf;
    flags.h = nib5[4];
    flags.n = res[7];
    flags.z = (res == 8'h00);
    flags.c = carry;
  end

endmodule
`default_nettype wire

// *** hdl/cpr_regs.sv ***
// programmer-visible register set of the eight-bit core with reset vector fetch
//
// Summary of operation
// - accumulator is eight bits, kept through reset
// - accumulator feeds alu, results written back
// - index pointer built from two byte halves
// - indexed modes use full pointer; none low-only
// - reset clears high index byte only
// - low index byte works as data register
// - stack pointer sixteen bits, next free slot
// - calls push return; interrupts push registers too
// - add signed immediate to whole stack pointer
// - reset loads stack pointer with 0x00ff
// - stack low reload leaves high byte alone
// - program counter sixteen bits, steps each fetch
// - change of flow loads non-sequential target
// - after reset fetch vector from fffe/ffff
// - direct mode reaches only 0x0000 to 0x00ff
// - relative target is pc plus signed offset
// - extended mode takes full sixteen-bit address
// - registers reached only by instructions, unmapped
// - condition flags bits six and five read one
`timescale 1ns/1ps
`default_nettype none
module cpr_regs
  import cpr_pkg::*;
(
  // clock, reset and enable
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  input  wire logic         ce,
  // sequencer command port
  input  wire cpr_cmd_type  cmd,
  input  wire logic         cmdValid,
  output logic              cmdReady,
  // core memory bus
  output logic [15:0]       memAddr,
  output logic              memRd,
  output logic              memWr,
  output logic [7:0]        memWdata,
  input  wire logic [7:0]   memRdata,
  input  wire logic         memReady,
  // fetched byte and register view
  output logic [7:0]        fetchByte,
  output logic              fetchValid,
  output cpr_view_type      regView
);

  // ***********************************************************
  // state
  // ***********************************************************
  typedef struct packed {
    cpr_state_type st;
    logic [15:0]   pc;
    logic [15:0]   sp;
    logic [7:0]    hi;
    logic [7:0]    condition_flags;
    logic [15:0]   addr;
    logic [7:0]    wdata;
    cpr_kind_type  kind;
    cpr_sel_type   sel;
    logic [7:0]    fbyte;
    logic          fvalid;
  } cpr_ctl_type;

  // the data registers keep their contents through reset, so they live apart
  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] lo;
  } cpr_data_type;

  cpr_ctl_type  ctl_r;
  cpr_ctl_type  ctl_nxt;
  cpr_data_type dat_r;
  cpr_data_type dat_nxt;
  logic [7:0]   aluA;
  logic [7:0]   aluRes;
  cpr_flag_type aluFlags;

  // ***********************************************************
  // address generation
  // ***********************************************************
  function automatic logic [15:0] effAddr(input cpr_mode_type m,
                                          input logic [15:0]  w,
                                          input logic [7:0]   b,
                                          input logic [15:0]  hx,
                                          input logic [15:0]  sp);
    unique case (m)
      CPR_AM_DIR: effAddr = {CPR_DIRECT_HI, b};
      CPR_AM_EXT: effAddr = w;
      CPR_AM_IDX: effAddr = hx + w;
      CPR_AM_SPX: effAddr = sp + w;
      default:    effAddr = w;
    endcase
  endfunction

  function automatic logic [7:0] pushData(input cpr_sel_type s,
                                          input cpr_ctl_type c,
                                          input cpr_data_type d);
    unique case (s)
      CPR_SEL_A:   pushData = d.acc;
      CPR_SEL_X:   pushData = d.lo;
      CPR_SEL_H:   pushData = c.hi;
      CPR_SEL_CCR: pushData = c.condition_flags;
      CPR_SEL_PCL: pushData = c.pc[7:0];
      CPR_SEL_PCH: pushData = c.pc[15:8];
      default:     pushData = 8'h00;
    endcase
  endfunction

  // ***********************************************************
  // alu
  // ***********************************************************
  assign aluA = (cmd.op == CPR_OP_ALU_X) ? dat_r.lo : dat_r.acc;

  cpr_alu8 u_alu (
    .op    (cmd.alu),
    .a     (aluA),
    .b     (cmd.imm8),
    .cin   (ctl_r.condition_flags[CPR_CCR_C]),
    .res   (aluRes),
    .flags (aluFlags)
  );

  // ***********************************************************
  // next state
  // ***********************************************************
  always_comb begin
    ctl_nxt        = ctl_r;
    dat_nxt        = dat_r;
    ctl_nxt.fvalid = 1'b0;
    unique case (ctl_r.st)
      CPR_ST_VEC_HI: begin
        if (memReady) begin
          ctl_nxt.pc[15:8] = memRdata;
          ctl_nxt.addr     = CPR_VEC_LO_ADDR;
          ctl_nxt.st       = CPR_ST_VEC_LO;
        end
      end
      CPR_ST_VEC_LO: begin
        if (memReady) begin
          ctl_nxt.pc[7:0] = memRdata;
          ctl_nxt.st      = CPR_ST_RUN;
        end
      end
      CPR_ST_MEM: begin
        if (memReady) begin
          ctl_nxt.st = CPR_ST_RUN;
          unique case (ctl_r.kind)
            CPR_MK_LOADA: dat_nxt.acc = memRdata;
            CPR_MK_FETCH: begin
              ctl_nxt.fbyte  = memRdata;
              ctl_nxt.fvalid = 1'b1;
              ctl_nxt.pc     = ctl_r.pc + CPR_PC_STEP;
            end
            CPR_MK_PUSH:  ctl_nxt.sp = ctl_r.sp - CPR_SP_STEP;
            CPR_MK_PULL: begin
              unique case (ctl_r.sel)
                CPR_SEL_A:   dat_nxt.acc = memRdata;
                CPR_SEL_X:   dat_nxt.lo = memRdata;
                CPR_SEL_H:   ctl_nxt.hi = memRdata;
                CPR_SEL_CCR: ctl_nxt.condition_flags = memRdata | CPR_CCR_FIXED;
                CPR_SEL_PCL: ctl_nxt.pc[7:0] = memRdata;
                CPR_SEL_PCH: ctl_nxt.pc[15:8] = memRdata;
                default:     ctl_nxt.sel = ctl_r.sel;
              endcase
            end
            CPR_MK_STORE: ctl_nxt.kind = ctl_r.kind;
            default:      ctl_nxt.kind = ctl_r.kind;
          endcase
        end
      end
      CPR_ST_RUN: begin
        if (cmdValid) begin
          unique case (cmd.op)
            CPR_OP_NOP: ctl_nxt.st = CPR_ST_RUN;
            CPR_OP_FETCH: begin
              ctl_nxt.addr = ctl_r.pc;
              ctl_nxt.kind = CPR_MK_FETCH;
              ctl_nxt.st   = CPR_ST_MEM;
            end
            CPR_OP_LOAD: begin
              if (cmd.mode == CPR_AM_IMM) begin
                dat_nxt.acc = cmd.imm8;
              end else begin
                ctl_nxt.addr = effAddr(cmd.mode, cmd.imm16, cmd.imm8,
                                       {ctl_r.hi, dat_r.lo}, ctl_r.sp);
                ctl_nxt.kind = CPR_MK_LOADA;
                ctl_nxt.st   = CPR_ST_MEM;
              end
            end
            CPR_OP_STORE: begin
              ctl_nxt.addr  = effAddr(cmd.mode, cmd.imm16, cmd.imm8,
                                      {ctl_r.hi, dat_r.lo}, ctl_r.sp);
              ctl_nxt.wdata = dat_r.acc;
              ctl_nxt.kind  = CPR_MK_STORE;
              ctl_nxt.st    = CPR_ST_MEM;
            end
            CPR_OP_ALU_A, CPR_OP_ALU_X: begin
              if (cmd.op == CPR_OP_ALU_A) begin
                dat_nxt.acc = aluRes;
              end else begin
                dat_nxt.lo = aluRes;
              end
              ctl_nxt.condition_flags[CPR_CCR_V] = aluFlags.v;
              ctl_nxt.condition_flags[CPR_CCR_H] = aluFlags.h;
              ctl_nxt.condition_flags[CPR_CCR_N] = aluFlags.n;
              ctl_nxt.condition_flags[CPR_CCR_Z] = aluFlags.z;
              ctl_nxt.condition_flags[CPR_CCR_C] = aluFlags.c;
            end
            CPR_OP_TAX:  dat_nxt.lo = dat_r.acc;
            CPR_OP_TXA:  dat_nxt.acc = dat_r.lo;
            CPR_OP_LDHX: begin
              ctl_nxt.hi = cmd.imm16[15:8];
              dat_nxt.lo = cmd.imm16[7:0];
            end
            CPR_OP_LDH:  ctl_nxt.hi = cmd.imm8;
            CPR_OP_LDX:  dat_nxt.lo = cmd.imm8;
            CPR_OP_AIS:  ctl_nxt.sp = ctl_r.sp + cpr_sext8(cmd.imm8);
            CPR_OP_RSP:  ctl_nxt.sp[7:0] = CPR_SP_RESET[7:0];
            CPR_OP_LDSP: ctl_nxt.sp = cmd.imm16;
            CPR_OP_JUMP: begin
              ctl_nxt.pc = effAddr(cmd.mode, cmd.imm16, cmd.imm8,
                                   {ctl_r.hi, dat_r.lo}, ctl_r.sp);
            end
            CPR_OP_BRANCH: ctl_nxt.pc = ctl_r.pc + cpr_sext8(cmd.imm8);
            CPR_OP_PUSH: begin
              // calls stack the return bytes, interrupts add the core registers
              ctl_nxt.addr  = ctl_r.sp;
              ctl_nxt.wdata = pushData(cmd.sel, ctl_r, dat_r);
              ctl_nxt.kind  = CPR_MK_PUSH;
              ctl_nxt.st    = CPR_ST_MEM;
            end
            CPR_OP_PULL: begin
              ctl_nxt.sp   = ctl_r.sp + CPR_SP_STEP;
              ctl_nxt.addr = ctl_r.sp + CPR_SP_STEP;
              ctl_nxt.sel  = cmd.sel;
              ctl_nxt.kind = CPR_MK_PULL;
              ctl_nxt.st   = CPR_ST_MEM;
            end
            CPR_OP_SETCCR: ctl_nxt.condition_flags = cmd.imm8 | CPR_CCR_FIXED;
            default: ctl_nxt.st = CPR_ST_RUN;
          endcase
        end
      end
    endcase
  end

  // ***********************************************************
  // registers
  // ***********************************************************
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctl_r <= '{st:     CPR_ST_VEC_HI,
                 pc:     CPR_PC_RESET,
                 sp:     CPR_SP_RESET,
                 hi:     CPR_H_RESET,
                 condition_flags:    CPR_CCR_RESET,
                 addr:   CPR_VEC_HI_ADDR,
                 wdata:  8'h00,
                 kind:   CPR_MK_STORE,
                 sel:    CPR_SEL_A,
                 fbyte:  8'h00,
                 fvalid: 1'b0};
    end else if (ce) begin
      ctl_r <= ctl_nxt;
    end
  end

  // no reset here: accumulator and low index byte survive reset untouched
  always_ff @(posedge clk_sys) begin
    if (ce) begin
      dat_r <= dat_nxt;
    end
  end

  // ***********************************************************
  // outputs
  // ***********************************************************
  // the bus only carries memory traffic; register contents never get an address
  assign memAddr    = ctl_r.addr;
  assign memWdata   = ctl_r.wdata;
  assign memWr      = (ctl_r.st == CPR_ST_MEM) &&
                      ((ctl_r.kind == CPR_MK_PUSH) || (ctl_r.kind == CPR_MK_STORE));
  assign memRd      = (ctl_r.st == CPR_ST_VEC_HI) || (ctl_r.st == CPR_ST_VEC_LO) ||
                      ((ctl_r.st == CPR_ST_MEM) && !memWr);
  assign cmdReady   = (ctl_r.st == CPR_ST_RUN);
  assign fetchByte  = ctl_r.fbyte;
  assign fetchValid = ctl_r.fvalid;
  assign regView    = '{acc: dat_r.acc,
                        hx:  {ctl_r.hi, dat_r.lo},
                        sp:  ctl_r.sp,
                        pc:  ctl_r.pc,
                        condition_flags: ctl_r.condition_flags | CPR_CCR_FIXED};

endmodule
`default_nettype wire

// *** sim/cpr_regs_checker.sv ***
// port-level assertions for the programmer register set
`timescale 1ns/1ps
`default_nettype none
module cpr_regs_checker
  import cpr_pkg::*;
(
  // clock and reset
  input wire logic         clk_sys,
  input wire logic         nrst,
  input wire logic         ce,
  // command port
  input wire cpr_cmd_type  cmd,
  input wire logic         cmdValid,
  input wire logic         cmdReady,
  // memory bus
  input wire logic [15:0]  memAddr,
  input wire logic         memRd,
  input wire logic         memWr,
  input wire logic [7:0]   memWdata,
  input wire logic [7:0]   memRdata,
  input wire logic         memReady,
  // results
  input wire logic [7:0]   fetchByte,
  input wire logic         fetchValid,
  input wire cpr_view_type regView
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic        take;
  logic        done;
  logic [15:0] sx;
  assign take = cmdValid && cmdReady && ce;
  assign done = memReady && ce;
  assign sx   = {{8{cmd.imm8[7]}}, cmd.imm8};
  // ********************
  // assertions
  // ********************
  a_vector_hi_first: assert property (!$past(nrst) |-> memRd && memAddr == 16'hfffe)
    else $error("vector read does not start at fffe");
  a_vector_lo_next: assert property (memRd && memAddr == 16'hfffe && done |=>
    memRd && memAddr == 16'hffff) else $error("vector low byte not read next");
  a_vector_to_pc: assert property (memRd && memAddr == 16'hffff && done |=>
    regView.pc[7:0] == $past(memRdata) && $stable(regView.pc[15:8]) && cmdReady)
    else $error("vector low byte not placed in pc");
  a_reset_values: assert property (!$past(nrst) |->
    regView.sp == 16'h00ff && regView.hx[15:8] == 8'h00) else $error("bad reset values");
  a_flags_fixed: assert property (regView.condition_flags[6:5] == 2'b11)
    else $error("flag bits six and five not one");
  a_fetch_step: assert property (fetchValid |-> fetchByte == $past(memRdata) &&
    regView.pc == $past(memAddr) + 16'h0001) else $error("fetch did not step pc");
  a_push_order: assert property (memWr && memAddr == regView.sp && done |=>
    regView.sp == $past(memAddr) - 16'h0001) else $error("push did not decrement");
  a_pull_order: assert property (take && cmd.op == CPR_OP_PULL |=>
    memRd && memAddr == regView.sp && regView.sp == $past(regView.sp) + 16'h0001)
    else $error("pull did not increment first");
  a_rsp_low: assert property (take && cmd.op == CPR_OP_RSP |=>
    $stable(regView.sp[15:8]) && regView.sp[7:0] == 8'hff) else $error("stack reload wrong");
  a_ais_add: assert property (take && cmd.op == CPR_OP_AIS |=>
    regView.sp == $past(regView.sp) + $past(sx)) else $error("signed stack add wrong");
  c_push: cover property (take && cmd.op == CPR_OP_PUSH);
  c_pull: cover property (take && cmd.op == CPR_OP_PULL);
  c_fetch: cover property (fetchValid);
endmodule
bind cpr_regs cpr_regs_checker u_chk (.clk_sys, .nrst, .ce, .cmd, .cmdValid, .cmdReady,
  .memAddr, .memRd, .memWr, .memWdata, .memRdata, .memReady, .fetchByte, .fetchValid, .regView);
`default_nettype wire

// *** sim/cpr_mem_model.sv ***
// memory on the core bus with a settable number of wait cycles
`timescale 1ns/1ps
`default_nettype none
module cpr_mem_model (
  // clock and reset
  input wire logic         clk_sys,
  input wire logic         nrst,
  input wire logic         ce,
  // bus
  input wire logic [15:0]  memAddr,
  input wire logic         memRd,
  input wire logic         memWr,
  input wire logic [7:0]   memWdata,
  input wire logic [1:0]   waitCycles,
  output logic [7:0]       memRdata,
  output logic             memReady
);
  logic [7:0] mem [0:65535];
  logic [1:0] cnt_r;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) cnt_r <= 2'h0;
    else if ((memRd || memWr) && !memReady) cnt_r <= cnt_r + 2'h1;
    else cnt_r <= 2'h0;
  end
  // plain always: the bench preloads this array, so it cannot be an always_ff target
  always @(posedge clk_sys) begin
    if (memWr && memReady && ce) mem[memAddr] <= memWdata;
  end
  assign memReady = (memRd || memWr) && (cnt_r >= waitCycles);
  // outside a completed read the data lines wander, so a late sample is caught
  assign memRdata = (memRd && memReady) ? mem[memAddr] : ~memAddr[7:0];
endmodule
`default_nettype wire

// *** sim/tb_cpr_regs.sv ***
// self-checking testbench of the programmer register set
`timescale 1ns/1ps
`default_nettype none
module tb_cpr_regs
  import cpr_pkg::*;
;
  logic         clk_sys, nrst, ce, cmdValid, cmdReady, memRd, memWr, memReady, fetchValid;
  logic [15:0]  memAddr, busAddr;
  logic [7:0]   memWdata, memRdata, fetchByte;
  logic [1:0]   waitCycles;
  cpr_cmd_type  cmd;
  cpr_view_type regView;
  int           n_fail, n_compared;
  cpr_regs DUT (.clk_sys, .nrst, .ce, .cmd, .cmdValid, .cmdReady, .memAddr, .memRd, .memWr,
    .memWdata, .memRdata, .memReady, .fetchByte, .fetchValid, .regView);
  cpr_mem_model u_mem (.clk_sys, .nrst, .ce, .memAddr, .memRd, .memWr, .memWdata, .waitCycles,
    .memRdata, .memReady);
  initial clk_sys = 1'b0;
  always #2 clk_sys = ~clk_sys;
  // ********************
  // shared tasks
  // ********************
  task automatic summarize();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // holds the command until taken, then waits for the block to be ready again
  task automatic issue(input cpr_op_type op, input logic [7:0] i8, input logic [15:0] i16,
      input cpr_mode_type md = CPR_AM_IMM, input cpr_alu_type alu = CPR_ALU_ADD,
      input cpr_sel_type sel = CPR_SEL_A);
    int k;
    k = 0;
    @(posedge clk_sys);
    cmd <= '{op, md, alu, sel, i8, i16};
    cmdValid <= 1'b1;
    do begin
      @(posedge clk_sys);
      k++;
    end while (!cmdReady && k < 40);
    cmdValid <= 1'b0;
    #1;
    if (memRd || memWr) busAddr = memAddr;
    while (!cmdReady && k < 40) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    if (k >= 40) begin
      n_fail++;
      summarize();
    end
  endtask
  // ********************
  // scenarios
  // ********************
  task automatic t_reset(input logic [1:0] w);
    @(posedge clk_sys);
    nrst <= 1'b0;
    waitCycles <= w;
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    issue(CPR_OP_NOP, 8'h00, 16'h0000);
    check(regView.pc, 16'hc123);
    check(regView.sp, 16'h00ff);
    check({8'h00, regView.hx[15:8]}, 16'h0000);
    check({8'h00, regView.condition_flags}, 16'h0068);
  endtask
  task automatic t_regs();
    cpr_alu_type ops[10] = '{CPR_ALU_CLR, CPR_ALU_INC, CPR_ALU_DEC, CPR_ALU_COM, CPR_ALU_NEG,
      CPR_ALU_LSL, CPR_ALU_LSR, CPR_ALU_ASR, CPR_ALU_ROL, CPR_ALU_ROR};
    logic [7:0] res[10] = '{8'h00, 8'h97, 8'h95, 8'h69, 8'h6a, 8'h2c, 8'h4b, 8'hcb, 8'h2d, 8'hcb};
    issue(CPR_OP_LDHX, 8'h00, 16'h5a3c);
    check(regView.hx, 16'h5a3c);
    issue(CPR_OP_LOAD, 8'h77, 16'h0000);
    issue(CPR_OP_ALU_A, 8'h11, 16'h0000);
    check({8'h00, regView.acc}, 16'h0088);
    issue(CPR_OP_TXA, 8'h00, 16'h0000);
    check({8'h00, regView.acc}, 16'h003c);
    for (int i = 0; i < 10; i++) begin
      issue(CPR_OP_LDHX, 8'h00, 16'h5a96);
      issue(CPR_OP_SETCCR, 8'h01, 16'h0000);
      issue(CPR_OP_ALU_X, 8'h00, 16'h0000, CPR_AM_IMM, ops[i]);
      check(regView.hx, {8'h5a, res[i]});
    end
    issue(CPR_OP_TAX, 8'h00, 16'h0000);
    check(regView.hx, 16'h5a3c);
    issue(CPR_OP_AIS, 8'h7f, 16'h0000);
    check(regView.sp, 16'h017e);
    issue(CPR_OP_AIS, 8'h82, 16'h0000);
    check(regView.sp, 16'h0100);
    issue(CPR_OP_RSP, 8'h00, 16'h0000);
    check(regView.sp, 16'h01ff);
    issue(CPR_OP_BRANCH, 8'hf0, 16'h0000);
    check(regView.pc, 16'hc113);
    issue(CPR_OP_JUMP, 8'h00, 16'h8000, CPR_AM_EXT);
    check(regView.pc, 16'h8000);
    issue(CPR_OP_SETCCR, 8'h00, 16'h0000);
    check({8'h00, regView.condition_flags}, 16'h0060);
  endtask
  task automatic t_mem();
    waitCycles <= 2'h1;
    issue(CPR_OP_FETCH, 8'h00, 16'h0000);
    check(busAddr, 16'h8000);
    check({8'h00, fetchByte}, 16'h00a5);
    check({15'h0000, fetchValid}, 16'h0001);
    check(regView.pc, 16'h8001);
    issue(CPR_OP_LOAD, 8'h42, 16'hffff, CPR_AM_DIR);
    check(busAddr, 16'h0042);
    issue(CPR_OP_LOAD, 8'h00, 16'h0010, CPR_AM_IDX);
    check(busAddr, 16'h5a4c);
    issue(CPR_OP_LOAD, 8'h00, 16'h1234, CPR_AM_EXT);
    check({8'h00, regView.acc}, 16'h005b);
    issue(CPR_OP_PUSH, 8'h00, 16'h0000, CPR_AM_IMM, CPR_ALU_ADD, CPR_SEL_A);
    check(busAddr, 16'h01ff);
    check({8'h00, u_mem.mem[16'h01ff]}, 16'h005b);
    issue(CPR_OP_PUSH, 8'h00, 16'h0000, CPR_AM_IMM, CPR_ALU_ADD, CPR_SEL_PCL);
    issue(CPR_OP_PUSH, 8'h00, 16'h0000, CPR_AM_IMM, CPR_ALU_ADD, CPR_SEL_PCH);
    check(regView.sp, 16'h01fc);
    issue(CPR_OP_PULL, 8'h00, 16'h0000, CPR_AM_IMM, CPR_ALU_ADD, CPR_SEL_A);
    check(busAddr, 16'h01fd);
    check({8'h00, regView.acc}, 16'h0080);
    issue(CPR_OP_PULL, 8'h00, 16'h0000, CPR_AM_IMM, CPR_ALU_ADD, CPR_SEL_X);
    check(regView.hx, 16'h5a01);
    issue(CPR_OP_STORE, 8'h00, 16'h0300, CPR_AM_EXT);
    check(busAddr, 16'h0300);
    check({8'h00, u_mem.mem[16'h0300]}, 16'h0080);
    issue(CPR_OP_LDSP, 8'h00, 16'h0280);
    check(regView.sp, 16'h0280);
    issue(CPR_OP_LOAD, 8'h00, 16'h0080, CPR_AM_SPX);
    check(busAddr, 16'h0300);
    check({8'h00, regView.acc}, 16'h0080);
    issue(CPR_OP_LDH, 8'h12, 16'h0000);
    check(regView.hx, 16'h1201);
  endtask
  // accumulator and low index byte must survive a second reset
  task automatic t_keep();
    // with the enable low a command must leave no trace
    @(posedge clk_sys);
    ce <= 1'b0;
    issue(CPR_OP_LOAD, 8'h33, 16'h0000);
    check({8'h00, regView.acc}, 16'h0080);
    @(posedge clk_sys);
    ce <= 1'b1;
    issue(CPR_OP_LOAD, 8'h77, 16'h0000);
    t_reset(2'h0);
    check({8'h00, regView.acc}, 16'h0077);
    check({8'h00, regView.hx[7:0]}, 16'h0001);
  endtask
  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    cmdValid = 1'b0;
    cmd = '0;
    waitCycles = 2'h0;
    n_fail = 0;
    n_compared = 0;
    u_mem.mem[16'hfffe] = 8'hc1;
    u_mem.mem[16'hffff] = 8'h23;
    u_mem.mem[16'h8000] = 8'ha5;
    u_mem.mem[16'h1234] = 8'h5b;
    t_reset(2'h2);
    t_regs();
    t_mem();
    t_keep();
    summarize();
  end
endmodule
`default_nettype wire
